// >>> common/sfdr_regs.svh
// Register offsets, field positions, reset values and timing counts.
// Assumes one include per compile unit and a 50 MHz system clock.
`ifndef SFDR_REGS_SVH
`define SFDR_REGS_SVH
// Register byte offsets.
`define SFDR_CMD_OFF 8'h00
`define SFDR_ENA_OFF 8'h04
`define SFDR_OPT_OFF 8'h08
`define SFDR_DMY_OFF 8'h0c
`define SFDR_EXT_OFF 8'h10
`define SFDR_RATE_OFF 8'h14
`define SFDR_ADJ_OFF 8'h18
`define SFDR_STAT_OFF 8'h1c
// Field positions in the phase enable register.
`define SFDR_ASEL_LSB 0
`define SFDR_AW_LSB 4
`define SFDR_OPE_LSB 8
`define SFDR_OW_LSB 12
`define SFDR_DME_BIT 16
`define SFDR_DW_LSB 20
// Field positions in the other registers.
`define SFDR_DMC_LSB 4
`define SFDR_EAV_LSB 8
`define SFDR_OTA_LSB 16
// Reset values and field codes.
`define SFDR_CMD_RST 8'h03
`define SFDR_ASEL_RST 4'h7
`define SFDR_ASEL_32 4'hf
`define SFDR_W_QUAD 2'h2
`define SFDR_OPE_B3 3
`define SFDR_EAC_25 3'h0
`define SFDR_ISA_RST 4'h4
`define SFDR_OTA_RST 16'h0000
// Serial clock period and its count of system clocks.
`define SFDR_CLK_NS 20
`define SFDR_SCLK_NS 160
`define SFDR_DIV_CYC (`SFDR_SCLK_NS / `SFDR_CLK_NS)
`define SFDR_HALF_CYC (`SFDR_DIV_CYC / 2)
`endif

// >>> common/sfdr_pkg.sv
// Types shared by the direct read controller.
// Assumes the constants header is compiled alongside.
package sfdr_pkg;
  // Sequencer phases of one flash read.
  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_OPT, ST_DUMMY, ST_DATA, ST_DONE
  } sfdr_state_t;
  // Software settings that steer each read.
  typedef struct packed {
    logic [7:0] read_cmd;
    logic [3:0] addr_phase_select;
    logic [1:0] addr_phase_width;
    logic [3:0] option_byte_enable;
    logic [1:0] option_phase_width;
    logic dummy_insert_enable;
    logic [1:0] read_data_width;
    logic [31:0] option_bytes;
    logic [1:0] dummy_phase_width;
    logic [2:0] dummy_count;
    logic [2:0] extended_addr_control;
    logic [7:0] extended_addr_value;
    logic [2:0] rate_select;
    logic [3:0] input_sample_adjust;
    logic [15:0] output_timing_adjust;
  } sfdr_cfg_t;
endpackage : sfdr_pkg

// >>> rtl/sfdr_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
module sfdr_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH]; // Storage words.
  logic [AW:0] wp_q, wp_d, rp_q, rp_d; // Pointers with wrap bit.
  logic push, pop;

  // Full when pointers differ only in the wrap bit.
  assign in_ready_o = !((wp_q[AW] != rp_q[AW]) &&
                        (wp_q[AW-1:0] == rp_q[AW-1:0]));
  assign out_valid_o = (wp_q != rp_q);
  assign out_data_o = mem_q[rp_q[AW-1:0]];
  assign count_o = wp_q - rp_q;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Pointer advance.
  always_comb begin
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
  end

  // Pointer and storage registers.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= in_data_i;
    end
  end
endmodule // sfdr_fifo

// >>> rtl/sfdr_top.sv
// Direct read sequencer for a quad-capable serial flash.
// Assumes a 50 MHz clock, a synchronous reset and a flash in mode 0.
`include "sfdr_regs.svh"
module sfdr_top
  import sfdr_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  input wire logic rd_req_i,
  input wire logic [25:0] rd_addr_i,
  output logic rd_ready_o,
  output logic rd_valid_o,
  output logic [31:0] rd_data_o,
  input wire logic rd_accept_i,
  output logic flash_serial_clock_o,
  output logic flash_select_n_o,
  output logic [3:0] flash_io_o,
  output logic [3:0] flash_io_oe_o,
  input wire logic [3:0] flash_io_i
);
  // -------------------------------------------------------------
  // Constants
  // -------------------------------------------------------------
  localparam logic [2:0] DIV_LAST = 3'(`SFDR_DIV_CYC - 1);
  localparam logic [2:0] DIV_HALF = 3'(`SFDR_HALF_CYC);
  // Boot defaults: plain read, 24-bit address, all single line.
  localparam sfdr_cfg_t CFG_RST = '{
    read_cmd: `SFDR_CMD_RST,
    addr_phase_select: `SFDR_ASEL_RST,
    input_sample_adjust: `SFDR_ISA_RST,
    output_timing_adjust: `SFDR_OTA_RST,
    default: '0
  };

  // -------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------
  sfdr_cfg_t cfg_q, cfg_d; // Software settings.
  logic [31:0] rdata_q, rdata_d; // Read data, one cycle late.
  sfdr_state_t st_q, st_d; // Sequencer phase.
  logic [2:0] div_q, div_d; // Position in one serial clock.
  logic [5:0] left_q, left_d; // Serial clocks left in phase.
  logic [31:0] shift_q, shift_d; // Outgoing bits, MSB first.
  logic [31:0] rx_q, rx_d; // Incoming data word.
  logic [31:0] faddr_q, faddr_d; // Flash address of this read.
  logic sclk_q, sclk_d; // Serial clock out.
  logic sel_n_q, sel_n_d; // Select out, active low.
  logic [3:0] io_q, io_d; // Data lines out.
  logic [3:0] oe_q, oe_d; // Data line enables.
  logic [3:0] io_m_q, io_s_q; // Two-stage line synchroniser.
  logic aquad, oquad, dquad; // Phase uses four lines.
  logic a32, opt_on, tick_end, accept, busy, wide_now, wide_nxt;
  logic push, fifo_rdy;
  logic [4:0] fifo_cnt;

  // -------------------------------------------------------------
  // Register port
  // -------------------------------------------------------------
  // Decodes writes into settings and reads into next data.
  always_comb begin
    cfg_d = cfg_q;
    rdata_d = '0;
    if (reg_we_i) begin
      if (reg_addr_i == `SFDR_CMD_OFF) begin
        cfg_d.read_cmd = reg_wdata_i[7:0];
      end else if (reg_addr_i == `SFDR_ENA_OFF) begin
        cfg_d.addr_phase_select = reg_wdata_i[`SFDR_ASEL_LSB +: 4];
        cfg_d.addr_phase_width = reg_wdata_i[`SFDR_AW_LSB +: 2];
        cfg_d.option_byte_enable = reg_wdata_i[`SFDR_OPE_LSB +: 4];
        cfg_d.option_phase_width = reg_wdata_i[`SFDR_OW_LSB +: 2];
        cfg_d.dummy_insert_enable = reg_wdata_i[`SFDR_DME_BIT];
        cfg_d.read_data_width = reg_wdata_i[`SFDR_DW_LSB +: 2];
      end else if (reg_addr_i == `SFDR_OPT_OFF) begin
        cfg_d.option_bytes = reg_wdata_i;
      end else if (reg_addr_i == `SFDR_DMY_OFF) begin
        cfg_d.dummy_phase_width = reg_wdata_i[1:0];
        cfg_d.dummy_count = reg_wdata_i[`SFDR_DMC_LSB +: 3];
      end else if (reg_addr_i == `SFDR_EXT_OFF) begin
        cfg_d.extended_addr_control = reg_wdata_i[2:0];
        cfg_d.extended_addr_value = reg_wdata_i[`SFDR_EAV_LSB +: 8];
      end else if (reg_addr_i == `SFDR_RATE_OFF) begin
        cfg_d.rate_select = reg_wdata_i[2:0];
      end else if (reg_addr_i == `SFDR_ADJ_OFF) begin
        cfg_d.input_sample_adjust = reg_wdata_i[3:0];
        cfg_d.output_timing_adjust =
          reg_wdata_i[`SFDR_OTA_LSB +: 16];
      end
    end
    if (reg_re_i) begin
      if (reg_addr_i == `SFDR_CMD_OFF) begin
        rdata_d[7:0] = cfg_q.read_cmd;
      end else if (reg_addr_i == `SFDR_ENA_OFF) begin
        rdata_d[`SFDR_ASEL_LSB +: 4] = cfg_q.addr_phase_select;
        rdata_d[`SFDR_AW_LSB +: 2] = cfg_q.addr_phase_width;
        rdata_d[`SFDR_OPE_LSB +: 4] = cfg_q.option_byte_enable;
        rdata_d[`SFDR_OW_LSB +: 2] = cfg_q.option_phase_width;
        rdata_d[`SFDR_DME_BIT] = cfg_q.dummy_insert_enable;
        rdata_d[`SFDR_DW_LSB +: 2] = cfg_q.read_data_width;
      end else if (reg_addr_i == `SFDR_OPT_OFF) begin
        rdata_d = cfg_q.option_bytes;
      end else if (reg_addr_i == `SFDR_DMY_OFF) begin
        rdata_d[1:0] = cfg_q.dummy_phase_width;
        rdata_d[`SFDR_DMC_LSB +: 3] = cfg_q.dummy_count;
      end else if (reg_addr_i == `SFDR_EXT_OFF) begin
        rdata_d[2:0] = cfg_q.extended_addr_control;
        rdata_d[`SFDR_EAV_LSB +: 8] = cfg_q.extended_addr_value;
      end else if (reg_addr_i == `SFDR_RATE_OFF) begin
        rdata_d[2:0] = cfg_q.rate_select;
      end else if (reg_addr_i == `SFDR_ADJ_OFF) begin
        rdata_d[3:0] = cfg_q.input_sample_adjust;
        rdata_d[`SFDR_OTA_LSB +: 16] = cfg_q.output_timing_adjust;
      end else if (reg_addr_i == `SFDR_STAT_OFF) begin
        rdata_d[0] = busy; // Sequencer in a read.
        rdata_d[8 +: 5] = fifo_cnt; // Words waiting.
      end
    end
  end

  // Settings and read data registers.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cfg_q <= CFG_RST;
      rdata_q <= '0;
    end else begin
      cfg_q <= cfg_d;
      rdata_q <= rdata_d;
    end
  end
  assign reg_rdata_o = rdata_q;

  // -------------------------------------------------------------
  // Line synchroniser
  // -------------------------------------------------------------
  // Flash lines come from outside; only the second stage is read.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      io_m_q <= '0;
      io_s_q <= '0;
    end else begin
      io_m_q <= flash_io_i;
      io_s_q <= io_m_q;
    end
  end

  // -------------------------------------------------------------
  // Sequencer
  // -------------------------------------------------------------
  // Width decodes; codes other than four-line mean one line.
  assign aquad = cfg_q.addr_phase_width == `SFDR_W_QUAD;
  assign oquad = cfg_q.option_phase_width == `SFDR_W_QUAD;
  assign dquad = cfg_q.read_data_width == `SFDR_W_QUAD;
  assign a32 = cfg_q.addr_phase_select == `SFDR_ASEL_32;
  assign opt_on = cfg_q.option_byte_enable[`SFDR_OPE_B3];
  assign tick_end = div_q == DIV_LAST;
  assign busy = st_q != ST_IDLE;
  assign rd_ready_o = (st_q == ST_IDLE) && fifo_rdy;
  assign accept = rd_req_i && rd_ready_o;
  assign push = (st_q == ST_DONE) && (div_q == 3'h0);
  assign wide_now = (st_q == ST_ADDR && aquad) ||
                    (st_q == ST_OPT && oquad) ||
                    (st_q == ST_DATA && dquad);

  // Walks command, address, option, dummy and data phases.
  // Bits change as the serial clock falls and the flash samples
  // on the rise; input is taken in the last cycle of a period,
  // which hides the two-stage synchroniser delay.
  always_comb begin
    st_d = st_q;
    div_d = (st_q == ST_IDLE) ? 3'h0 : div_q + 3'h1;
    left_d = left_q;
    shift_d = shift_q;
    rx_d = rx_q;
    faddr_d = faddr_q;
    case (st_q)
      ST_IDLE: begin
        if (accept) begin
          st_d = ST_CMD;
          shift_d = {cfg_q.read_cmd, 24'h0};
          left_d = 6'd8;
          if (cfg_q.extended_addr_control == `SFDR_EAC_25) begin
            faddr_d = {cfg_q.extended_addr_value[6:0],
                       rd_addr_i[24:0]};
          end else begin
            faddr_d = {cfg_q.extended_addr_value[5:0],
                       rd_addr_i};
          end
        end
      end
      ST_DONE: begin
        if (tick_end) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        if (tick_end) begin
          // Every phase is single data rate, one step per clock.
          shift_d = wide_now ? {shift_q[27:0], 4'h0} :
                               {shift_q[30:0], 1'b0};
          left_d = left_q - 6'd1;
          if (st_q == ST_DATA) begin
            rx_d = wide_now ? {rx_q[27:0], io_s_q} :
                              {rx_q[30:0], io_s_q[1]};
          end
          if (left_q == 6'd1) begin
            if (st_q == ST_CMD) begin
              st_d = ST_ADDR;
              shift_d = a32 ? faddr_q : {faddr_q[23:0], 8'h0};
              left_d = a32 ? (aquad ? 6'd8 : 6'd32) :
                             (aquad ? 6'd6 : 6'd24);
            end else if (st_q == ST_ADDR && opt_on) begin
              st_d = ST_OPT;
              shift_d = {cfg_q.option_bytes[31:24], 24'h0};
              left_d = oquad ? 6'd2 : 6'd8;
            end else if ((st_q == ST_ADDR || st_q == ST_OPT) &&
                         cfg_q.dummy_insert_enable) begin
              st_d = ST_DUMMY;
              // One-bit dummy clocks; count code plus one.
              left_d = {3'h0, cfg_q.dummy_count} + 6'd1;
            end else if (st_q == ST_DATA) begin
              st_d = ST_DONE;
            end else begin
              st_d = ST_DATA;
              left_d = dquad ? 6'd8 : 6'd32;
            end
          end
        end
      end
    endcase
  end

  // Pin values follow the next phase so they leave flip-flops.
  always_comb begin
    wide_nxt = (st_d == ST_ADDR && aquad) ||
               (st_d == ST_OPT && oquad);
    sel_n_d = (st_d == ST_IDLE) || (st_d == ST_DONE);
    sclk_d = !sel_n_d && (div_d >= DIV_HALF);
    io_d = wide_nxt ? shift_d[31:28] : {3'h0, shift_d[31]};
    if (st_d == ST_CMD || st_d == ST_ADDR || st_d == ST_OPT) begin
      oe_d = wide_nxt ? 4'hf : 4'h1;
    end else begin
      oe_d = 4'h0; // Dummy and data leave the lines to the flash.
    end
  end

  // Sequencer registers.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_q <= ST_IDLE;
      div_q <= '0;
      left_q <= '0;
      shift_q <= '0;
      rx_q <= '0;
      faddr_q <= '0;
      sclk_q <= 1'b0;
      sel_n_q <= 1'b1;
      io_q <= '0;
      oe_q <= '0;
    end else begin
      st_q <= st_d;
      div_q <= div_d;
      left_q <= left_d;
      shift_q <= shift_d;
      rx_q <= rx_d;
      faddr_q <= faddr_d;
      sclk_q <= sclk_d;
      sel_n_q <= sel_n_d;
      io_q <= io_d;
      oe_q <= oe_d;
    end
  end
  assign flash_serial_clock_o = sclk_q;
  assign flash_select_n_o = sel_n_q;
  assign flash_io_o = io_q;
  assign flash_io_oe_o = oe_q;

  // -------------------------------------------------------------
  // Read data buffer
  // -------------------------------------------------------------
  // A read starts only with room, so the push is never refused.
  sfdr_fifo #(
    .WIDTH(32),
    .DEPTH(16)
  ) u_fifo (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(push),
    .in_ready_o(fifo_rdy),
    .in_data_i(rx_q),
    .out_valid_o(rd_valid_o),
    .out_ready_i(rd_accept_i),
    .out_data_o(rd_data_o),
    .count_o(fifo_cnt)
  );

  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_enter_addr;
    $past(st_q) == ST_CMD && st_q == ST_ADDR;
  endsequence
  sequence s_enter_dummy;
    $past(st_q) != ST_DUMMY && st_q == ST_DUMMY;
  endsequence

  a_select_held: assert property (
    (st_q inside {ST_CMD, ST_ADDR, ST_OPT, ST_DUMMY, ST_DATA})
      |-> !sel_n_q)
    else $error("select not asserted inside a read");
  a_cmd_first: assert property (
    accept |=> st_q == ST_CMD && shift_q[31:24] == cfg_q.read_cmd)
    else $error("read did not open with the command");
  a_addr_len: assert property (
    s_enter_addr |-> left_q == (a32 ? (aquad ? 6'd8 : 6'd32) :
                                      (aquad ? 6'd6 : 6'd24)))
    else $error("address phase length wrong");
  a_opt_skip: assert property (
    (st_q == ST_ADDR && !opt_on) |=> st_q != ST_OPT)
    else $error("option phase sent while disabled");
  a_quad_lines: assert property (
    (st_q == ST_ADDR && aquad && div_q == 3'h1) |-> oe_q == 4'hf)
    else $error("quad address not on four lines");
  a_no_dummy: assert property (
    (!cfg_q.dummy_insert_enable && st_q != ST_DUMMY)
      |=> st_q != ST_DUMMY)
    else $error("dummy inserted while disabled");
  a_dummy_len: assert property (
    s_enter_dummy |-> oe_q == 4'h0 &&
      left_q == {3'h0, cfg_q.dummy_count} + 6'd1)
    else $error("dummy length or lines wrong");
  a_sclk_high: assert property (
    $rose(sclk_q) |-> sclk_q [*4] ##1 !sclk_q)
    else $error("serial clock high time wrong");
  a_word_push: assert property (
    ($past(st_q) == ST_DATA && st_q == ST_DONE) |-> push)
    else $error("data word not buffered");
  a_boot_read: assert property (
    $past(sys_rst_i) |-> cfg_q.read_cmd == 8'h03 &&
      !a32 && !aquad && !cfg_q.dummy_insert_enable)
    else $error("reset settings wrong");
endmodule // sfdr_top

// >>> dv/sfdr_flash_model.sv
// Behavioural quad-capable serial flash that answers direct reads.
// Assumes mode 0: it samples on serial clock rise and drives on the fall.
module sfdr_flash_model #(
  parameter bit QUAD_ENABLE_BIT = 1'b1,
  parameter int DUMMY_CLKS = 2
) (
  input wire logic sclk_i,
  input wire logic sel_n_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [7:0] cmd_o,
  output logic [31:0] addr_o,
  output logic [7:0] opt_o,
  output int rises_o,
  output int frames_o,
  output logic enhance_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int a_end;
  int d_start;
  logic quad;
  logic [31:0] word;
  initial begin
    io_o = 4'h0;
    {cmd_o, addr_o, opt_o, enhance_o, quad} = '0;
    rises_o = 0;
    frames_o = 0;
  end
  // A new frame starts: clear captured command, address and option; enhance stays set.
  always @(negedge sel_n_i) begin
    frames_o++;
    rises_o = 0;
    {cmd_o, addr_o, opt_o, quad} = '0;
  end
  // Released lines show the inverse of their last value, never a hold.
  always @(posedge sel_n_i) begin
    io_o = ~io_o;
  end
  // Capture command, address and option bits on each rising edge.
  always @(posedge sclk_i) begin
    if (!sel_n_i) begin
      if (rises_o < 8) begin
        cmd_o = {cmd_o[6:0], io_i[0]};
      end else if (rises_o < a_end) begin
        addr_o = quad ? {addr_o[27:0], io_i} : {addr_o[30:0], io_i[0]};
      end else if (quad && rises_o < a_end + 2) begin
        opt_o = {opt_o[3:0], io_i};
      end
      rises_o++;
      if (rises_o == 8) begin
        quad = (cmd_o === 8'hec);
        a_end = quad ? 16 : ((cmd_o === 8'h13) ? 40 : 32);
        d_start = quad ? a_end + 2 + DUMMY_CLKS : a_end;
      end
      // Complementary nibbles in the indicator byte enter enhance mode.
      if (quad && rises_o == a_end + 2 && opt_o[7:4] == ~opt_o[3:0]) begin
        enhance_o = 1'b1;
      end
    end
  end
  // Shift read data out on the falling edge, MSB first.
  always @(negedge sclk_i) begin
    if (!sel_n_i && rises_o >= 8 && rises_o >= d_start) begin
      if (rises_o == d_start) begin
        word = addr_o ^ 32'h5a3c_96e1;
      end
      if (quad && QUAD_ENABLE_BIT) begin
        io_o = word[31:28];
        word = word << 4;
      end else if (!quad) begin
        io_o = {~io_o[3:2], word[31], ~io_o[0]};
        word = word << 1;
      end else begin
        io_o = ~io_o;
      end
    end else begin
      io_o = ~io_o;
    end
  end
endmodule // sfdr_flash_model

// >>> dv/serial_flash_direct_read_bench.sv
// Self-checking bench of the direct read sequencer with a flash model.
// Assumes the package, constants header and design files compile first.
`include "sfdr_regs.svh"
module serial_flash_direct_read_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_we_i = 1'b0;
  logic reg_re_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic rd_req_i = 1'b0;
  logic [25:0] rd_addr_i = 26'h0;
  logic rd_ready_o, rd_valid_o, rd_accept_i = 1'b0;
  logic [31:0] rd_data_o;
  logic sclk, sel_n;
  logic [3:0] io_o, io_oe, fl_drv, io_wire;
  logic [7:0] fl_cmd, fl_opt;
  logic [31:0] fl_addr;
  logic fl_enh;
  int fl_rises, fl_frames;
  int fail_count = 0;
  int n_compared = 0;
  // Wire level: each line is driven by whichever side enables it.
  assign io_wire = (io_oe & io_o) | (~io_oe & fl_drv);
  always #10 clk_i = ~clk_i;
  sfdr_top dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
    .rd_req_i(rd_req_i), .rd_addr_i(rd_addr_i), .rd_ready_o(rd_ready_o),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
    .rd_accept_i(rd_accept_i), .flash_serial_clock_o(sclk),
    .flash_select_n_o(sel_n), .flash_io_o(io_o), .flash_io_oe_o(io_oe),
    .flash_io_i(io_wire));
  sfdr_flash_model fl (.sclk_i(sclk), .sel_n_i(sel_n), .io_i(io_wire),
    .io_o(fl_drv), .cmd_o(fl_cmd), .addr_o(fl_addr), .opt_o(fl_opt),
    .rises_o(fl_rises), .frames_o(fl_frames), .enhance_o(fl_enh));
  // -------------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------------
  task automatic cmp(input string what, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic chk_reg(input string what, input logic [7:0] a,
                         input logic [31:0] e);
    @(posedge clk_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1 cmp(what, e, reg_rdata_o);
  endtask
  // Holds the request until an edge where ready is high takes it.
  task automatic issue(input logic [25:0] a);
    @(posedge clk_i);
    rd_req_i <= 1'b1;
    rd_addr_i <= a;
    @(negedge clk_i);
    while (rd_ready_o !== 1'b1) @(negedge clk_i);
    @(posedge clk_i);
    rd_req_i <= 1'b0;
  endtask
  task automatic pop();
    @(posedge clk_i);
    rd_accept_i <= 1'b1;
    @(posedge clk_i);
    rd_accept_i <= 1'b0;
  endtask
  // One whole read: latency, frame content and returned word.
  task automatic flash_read(input logic [7:0] cmd, input logic [25:0] a,
                            input logic [31:0] fa, input int rises);
    int n;
    int f0;
    f0 = fl_frames;
    issue(a);
    @(negedge clk_i);
    cmp("ready while busy", 32'h0, {31'h0, rd_ready_o});
    n = 1;
    while (rd_valid_o !== 1'b1 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    // Valid is seen 8 cycles per serial clock plus 2 after the take edge.
    cmp("latency", 8 * rises + 2, n);
    cmp("frames", f0 + 1, fl_frames);
    cmp("command", {24'h0, cmd}, {24'h0, fl_cmd});
    cmp("flash address", fa, fl_addr);
    cmp("serial clocks", rises, fl_rises);
    cmp("data", fa ^ 32'h5a3c_96e1, rd_data_o);
    pop();
    @(negedge clk_i);
    cmp("valid after pop", 32'h0, {31'h0, rd_valid_o});
  endtask
  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  task automatic t_defaults();
    chk_reg("cmd reset", `SFDR_CMD_OFF, 32'h0000_0003);
    chk_reg("enable reset", `SFDR_ENA_OFF, 32'h0000_0007);
    chk_reg("dummy reset", `SFDR_DMY_OFF, 32'h0);
    chk_reg("ext reset", `SFDR_EXT_OFF, 32'h0);
    chk_reg("rate reset", `SFDR_RATE_OFF, 32'h0);
    chk_reg("adjust reset", `SFDR_ADJ_OFF, 32'h0000_0004);
    wr(`SFDR_ADJ_OFF, 32'h1234_0009);
    chk_reg("adjust rw", `SFDR_ADJ_OFF, 32'h1234_0009);
    wr(`SFDR_ADJ_OFF, 32'h0000_0004);
    wr(`SFDR_STAT_OFF, 32'hffff_ffff);
    chk_reg("status ro", `SFDR_STAT_OFF, 32'h0);
    wr(8'h20, 32'hffff_ffff);
    chk_reg("unmapped", 8'h20, 32'h0);
  endtask
  // Boot defaults: opcode 03, 24-bit address on one line, no dummy.
  task automatic t_plain();
    flash_read(8'h03, 26'h212_3456, 32'h0012_3456, 64);
  endtask
  // 32-bit single line address, 25 bus bits plus extended value.
  task automatic t_ext();
    wr(`SFDR_CMD_OFF, 32'h0000_0013);
    wr(`SFDR_ENA_OFF, 32'h0000_000f);
    wr(`SFDR_EXT_OFF, 32'h0000_5500);
    flash_read(8'h13, 26'h3ab_cdef, 32'habab_cdef, 72);
  endtask
  // Quad I/O read with option byte three and two dummy clocks.
  task automatic t_quad();
    wr(`SFDR_CMD_OFF, 32'h0000_00ec);
    wr(`SFDR_ENA_OFF, 32'h0021_282f);
    wr(`SFDR_OPT_OFF, 32'h0000_0000);
    wr(`SFDR_DMY_OFF, 32'h0000_0010);
    wr(`SFDR_EXT_OFF, 32'h0000_0201);
    flash_read(8'hec, 26'h3ab_cdef, 32'h0bab_cdef, 28);
    cmp("option byte", 32'h0, {24'h0, fl_opt});
    cmp("enhance mode", 32'h0, {31'h0, fl_enh});
  endtask
  // Fill the buffer with the consumer stalled, then drain in order.
  task automatic t_fill();
    int hi;
    hi = 0;
    for (int i = 0; i < 16; i++) issue(26'h100 + 26'(i * 4));
    repeat (300) begin
      @(negedge clk_i);
      if (rd_ready_o !== 1'b0) hi++;
    end
    cmp("ready when full", 32'h0, hi);
    chk_reg("status full", `SFDR_STAT_OFF, 32'h0000_1000);
    for (int i = 0; i < 16; i++) begin
      @(negedge clk_i);
      cmp("drain data", (32'h0800_0100 + i * 4) ^ 32'h5a3c_96e1,
          rd_data_o);
      pop();
    end
    @(negedge clk_i);
    cmp("drained", 32'h0, {31'h0, rd_valid_o});
  endtask
  // -------------------------------------------------------------------
  // Closing and main sequence
  // -------------------------------------------------------------------
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Expected run is about 5500 cycles; cut a hang well beyond that.
  initial begin
    #400000;
    fail_count++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_defaults();
    t_plain();
    t_ext();
    t_quad();
    t_fill();
    complete_run();
  end
endmodule // serial_flash_direct_read_bench
